// ### color_frame_sequencer.v
/*
 Colour frame sequencer: reads frames from an external SRAM, unpacks pixels
 MSB first, drives palette address/DAC lines and times RGB backlight strobes.
 Assumes an APB master on the same clock and an asynchronous SRAM that
 returns read data within one clock of the address.
*/
// Design decisions made here: the register addresses and the APB register port.
// What this block does
// [RULE1] Register writes ignored while reset asserted
// [RULE2] Host sets soft reset and sleep
// [RULE3] Host programs all control bits itself
// [RULE4] Host clears both bits to display
// [RULE5] Drive SRAM address, data, write/output enables
// [RULE6] Start address 20 bits, MSB set
// [RULE7] Frames made of 40-byte rows
// [RULE8] First pixel taken from bit seven
// [RULE9] Frame starts at any programmed address
// [RULE10] Non-indexed colour: red, green, blue frames
// [RULE11] Host uses depth 4 or 8 indexed
// [RULE12] Four palette pages, two page bits
// [RULE13] Non-indexed modes drive page bits 11
// [RULE14] Colour and white bits select mode
// [RULE15] Monochrome strobes right after frame
// [RULE16] Colour-white: three passes, delayed strobes
// [RULE17] Non-indexed: frame then delayed strobe each
// [RULE18] Indexed: pages 00, 01, 10 in turn
// [RULE19] Palette data pins released in indexed mode
// [RULE20] Host sets both bits for indexed
// [RULE21] Depth code gives 1, 2, 4, 8 bits
// [RULE22] White bit 2, colour bit 3
// [RULE23] Strobe delay counted on system clock
// [RULE24] Frame is 240 rows of 320 pixels
`timescale 1ns/100ps
`include "frame_seq_consts.vh"

module color_frame_sequencer
#(
   parameter STROBE_DELAY = `STROBE_DELAY_CYC,
   parameter FRAME_LINES  = `FRAME_ROWS
)
(
   input  wire        clock,
   input  wire        rst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [18:0] sramAddrLines,
   input  wire [7:0]  sramDataIn,
   output wire [7:0]  sramDataOut,
   output wire        sramDataOe,
   output wire        sramWriteEnable_n,
   output wire        sramOutputEnable_n,
   output reg         palettePageHi,
   output reg         palettePageLo,
   output reg  [7:0]  paletteIndexLines,
   output wire [7:0]  paletteDataOut,
   output wire        paletteDataOe,
   output reg         redLedStrobe,
   output reg         greenLedStrobe,
   output reg         blueLedStrobe
);

   localparam ST_IDLE  = 4'b0001;
   localparam ST_FETCH = 4'b0010;
   localparam ST_SHIFT = 4'b0100;
   localparam ST_WAIT  = 4'b1000;

   reg [1:0]  ctrl_r;
   reg [3:0]  mode_r;
   reg [19:0] start_r;
   reg [3:0]  state_r;
   reg [19:0] addr_r;
   reg [19:0] passBase_r;
   reg [10:0] rowCnt_r;
   reg        rdDone_r;
   reg [5:0]  byteCnt_r;
   reg [7:0]  shift_r;
   reg [3:0]  pixLeft_r;
   reg [1:0]  pass_r;
   reg [31:0] delayCnt_r;

   wire       apbWrite   = psel && penable && pwrite;
   wire       apbRead    = psel && penable && !pwrite;
   wire       halted     = ctrl_r[`CTRL_SOFTRST_BIT] || ctrl_r[`CTRL_SLEEP_BIT];
   wire [1:0] depth      = mode_r[`MODE_DEPTH_LSB+1:`MODE_DEPTH_LSB];       // [RULE21]
   wire       whiteBit   = mode_r[`MODE_WHITE_BIT];                         // [RULE22]
   wire       colourBit  = mode_r[`MODE_COLOUR_BIT];                        // [RULE22]
   wire       monoMode   = !colourBit && !whiteBit;                         // [RULE14]
   wire       nonIdxMode = colourBit && !whiteBit;                          // [RULE14]
   wire       idxMode    = colourBit && whiteBit;                           // [RULE14]
   wire [3:0] pixPerByte = (depth == 2'h0) ? 4'h8 : (depth == 2'h1) ? 4'h4 :
                           (depth == 2'h2) ? 4'h2 : 4'h1;                   // [RULE21]
   localparam [5:0]  LAST_BYTE = `ROW_BYTES - 1;
   localparam [10:0] LINES     = FRAME_LINES;
   // A display line spans one 40-byte row per bit of depth
   wire [10:0] rowsLast  = (LINES << depth) - 11'h001;                     // [RULE24]
   wire       lastByte   = (byteCnt_r == LAST_BYTE);                       // [RULE7]
   wire       lastRow    = (rowCnt_r == rowsLast);                         // [RULE24]
   wire       lastPass   = monoMode || (pass_r == 2'h2);
   wire [1:0] nextPass   = lastPass ? 2'h0 : pass_r + 2'h1;
   reg  [7:0] pixel;

   // Reads take one wait state so prdata stands when pready is high
   assign pready  = !(apbRead && !rdDone_r);
   assign pslverr = 1'b0;
   // Reads only; the host port owns memory loading
   assign sramDataOut        = 8'h00;
   assign sramDataOe         = 1'b0;
   assign sramWriteEnable_n  = 1'b1;                                       // [RULE5]
   assign sramOutputEnable_n = !(state_r == ST_FETCH);                     // [RULE5]
   assign paletteDataOut     = 8'h00;
   assign paletteDataOe      = 1'b0;                                       // [RULE19]

   // Register file; synchronous reset blocks writes while low
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         ctrl_r  <= `CTRL_RESET_VAL;
         mode_r  <= `MODE_RESET_VAL;
         start_r <= `START_RESET_VAL;
      end
      else if (apbWrite)                                                  // [RULE1]
      begin
         case (paddr)
            `REG_CTRL_OFS:  ctrl_r  <= pwdata[1:0];
            `REG_MODE_OFS:  mode_r  <= pwdata[3:0];
            `REG_START_OFS: start_r <= {1'b1, pwdata[18:0]};               // [RULE6]
            default:        ctrl_r  <= ctrl_r;
         endcase
      end
   end

   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         prdata   <= 32'h00000000;
         rdDone_r <= 1'b0;
      end
      else
      begin
         rdDone_r <= apbRead && !rdDone_r;
      end
      if (rst_n && apbRead && !rdDone_r)
      begin
         case (paddr)
            `REG_CTRL_OFS:   prdata <= {30'h00000000, ctrl_r};
            `REG_MODE_OFS:   prdata <= {28'h0000000, mode_r};
            `REG_START_OFS:  prdata <= {12'h000, start_r};
            `REG_STATUS_OFS: prdata <= {26'h0000000, pass_r, state_r};
            default:         prdata <= 32'h00000000;
         endcase
      end
   end

   // Pixel taken from the top of the shift register, MSB first
   always @*
   begin
      case (depth)
         2'h0:    pixel = {8{shift_r[7]}};                                 // [RULE8]
         2'h1:    pixel = {4{shift_r[7:6]}};                               // [RULE8]
         2'h2:    pixel = {2{shift_r[7:4]}};                               // [RULE8]
         default: pixel = shift_r;
      endcase
   end

   always @(posedge clock)
   begin
      if (!rst_n || halted)
      begin
         state_r        <= ST_IDLE;
         addr_r         <= `START_RESET_VAL;
         passBase_r     <= `START_RESET_VAL;
         rowCnt_r       <= 11'h000;
         byteCnt_r      <= 6'h00;
         shift_r        <= 8'h00;
         pixLeft_r      <= 4'h0;
         pass_r         <= 2'h0;
         delayCnt_r     <= 32'h00000000;
         sramAddrLines  <= 19'h00000;
         paletteIndexLines <= 8'h00;
         palettePageHi  <= 1'b1;
         palettePageLo  <= 1'b1;
         redLedStrobe   <= 1'b0;
         greenLedStrobe <= 1'b0;
         blueLedStrobe  <= 1'b0;
      end
      else
      begin
         redLedStrobe   <= 1'b0;
         greenLedStrobe <= 1'b0;
         blueLedStrobe  <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               addr_r     <= start_r;                                     // [RULE9]
               passBase_r <= start_r;
               sramAddrLines <= start_r[18:0];                            // [RULE5]
               palettePageHi <= !idxMode;                                 // [RULE12] [RULE13]
               palettePageLo <= !idxMode;                                 // [RULE18]
               rowCnt_r   <= 11'h000;
               byteCnt_r  <= 6'h00;
               pass_r     <= 2'h0;
               state_r    <= ST_FETCH;
            end
            ST_FETCH:
            begin
               sramAddrLines <= addr_r[18:0] + 19'h00001;                 // [RULE5]
               shift_r   <= sramDataIn;
               pixLeft_r <= pixPerByte;
               addr_r    <= addr_r + 20'h00001;                           // [RULE24]
               state_r   <= ST_SHIFT;
            end
            ST_SHIFT:
            begin
               paletteIndexLines <= pixel;
               shift_r   <= shift_r << (8 / pixPerByte);                  // [RULE8]
               pixLeft_r <= pixLeft_r - 4'h1;
               if (pixLeft_r == 4'h1)
               begin
                  state_r   <= ST_FETCH;
                  byteCnt_r <= lastByte ? 6'h00 : byteCnt_r + 6'h01;     // [RULE7]
                  if (lastByte)
                  begin
                     rowCnt_r <= lastRow ? 11'h000 : rowCnt_r + 11'h001; // [RULE24]
                     if (lastRow)
                     begin
                        state_r    <= ST_WAIT;
                        delayCnt_r <= 32'h00000000;
                     end
                  end
               end
            end
            ST_WAIT:
            begin
               delayCnt_r <= delayCnt_r + 32'h00000001;                   // [RULE23]
               if (monoMode || delayCnt_r == STROBE_DELAY - 1)            // [RULE15]
               begin
                  if (monoMode)
                  begin
                     redLedStrobe   <= 1'b1;                               // [RULE15]
                     greenLedStrobe <= 1'b1;
                     blueLedStrobe  <= 1'b1;
                  end
                  else if (idxMode)
                  begin
                     blueLedStrobe  <= (pass_r == 2'h0);                  // [RULE18]
                     redLedStrobe   <= (pass_r == 2'h1);
                     greenLedStrobe <= (pass_r == 2'h2);
                  end
                  else
                  begin
                     redLedStrobe   <= (pass_r == 2'h0);                  // [RULE16] [RULE17]
                     greenLedStrobe <= (pass_r == 2'h1);
                     blueLedStrobe  <= (pass_r == 2'h2);
                  end
                  pass_r  <= nextPass;
                  state_r <= ST_FETCH;
                  palettePageHi <= idxMode ? (nextPass == 2'h2) : 1'b1;   // [RULE12] [RULE18]
                  palettePageLo <= idxMode ? (nextPass == 2'h1) : 1'b1;   // [RULE13]
                  if (lastPass)
                  begin
                     addr_r        <= start_r;
                     passBase_r    <= start_r;
                     sramAddrLines <= start_r[18:0];
                  end
                  else if (nonIdxMode)
                     passBase_r <= addr_r;                                // [RULE10]
                  else
                  begin
                     addr_r        <= passBase_r;                         // [RULE16] [RULE18]
                     sramAddrLines <= passBase_r[18:0];
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

endmodule // color_frame_sequencer

// ### frame_seq_assertions.sv
/*
 Checker for the colour frame sequencer ports.
 Assumes one clock and a synchronous active-low reset; bound from tb.
*/
`timescale 1ns/100ps
module frame_seq_assertions
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sramWriteEnable_n,
   input wire logic        sramDataOe,
   input wire logic        sramOutputEnable_n,
   input wire logic        paletteDataOe,
   input wire logic        redLedStrobe,
   input wire logic        greenLedStrobe,
   input wire logic        blueLedStrobe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire anyStrobe = redLedStrobe || greenLedStrobe || blueLedStrobe;

   a_ready_high: assert property (psel && penable && pwrite |-> pready && !pslverr)
      else $error("bus write not answered at once");
   a_read_wait: assert property (psel && penable && !pready |=> pready && !pslverr)
      else $error("bus read not answered after one wait");
   a_sram_readonly: assert property (sramWriteEnable_n && !sramDataOe)
      else $error("memory write side active");
   a_palette_released: assert property (!paletteDataOe)
      else $error("palette data pins driven");
   a_strobe_pulse: assert property (anyStrobe |=> !anyStrobe)
      else $error("strobe longer than one cycle");
   a_strobe_shape: assert property ($onehot0({redLedStrobe, greenLedStrobe, blueLedStrobe})
      || (redLedStrobe && greenLedStrobe && blueLedStrobe))
      else $error("strobe combination not allowed");
   a_fetch_single: assert property (!sramOutputEnable_n |=> sramOutputEnable_n)
      else $error("fetch without a pixel cycle");
   a_strobe_delayed: assert property ($onehot({redLedStrobe, greenLedStrobe, blueLedStrobe})
      |-> $past(sramOutputEnable_n, 1) && $past(sramOutputEnable_n, 4)
      && $past(sramOutputEnable_n, 8))
      else $error("colour strobe too soon after fetch");
   a_unmapped_zero: assert property (psel && penable && !pwrite && pready
      && paddr == 12'h010 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // frame_seq_assertions

// ### frame_seq_consts.vh
/*
 Constants for the colour frame sequencer: APB register offsets, control bit
 positions, reset values and timing counts. Assumes a 200 MHz system clock.
*/
`ifndef FRAME_SEQ_CONSTS_VH
`define FRAME_SEQ_CONSTS_VH

`define REG_CTRL_OFS       12'h000
`define REG_MODE_OFS       12'h004
`define REG_START_OFS      12'h008
`define REG_STATUS_OFS     12'h00C

`define CTRL_SOFTRST_BIT   1
`define CTRL_SLEEP_BIT     0
`define MODE_DEPTH_LSB     0
`define MODE_WHITE_BIT     2
`define MODE_COLOUR_BIT    3

`define CTRL_RESET_VAL     2'h3
`define MODE_RESET_VAL     4'h0
`define START_RESET_VAL    20'h80000

`define ROW_BYTES          40
`define FRAME_ROWS         240
`define STROBE_DELAY_NS    1300000
`define CLOCK_PERIOD_NS    5
`define STROBE_DELAY_CYC   (`STROBE_DELAY_NS / `CLOCK_PERIOD_NS)
`define STROBE_PULSE_CYC   1

`endif

// ### sram_model.sv
/*
 Far-side SRAM: a byte derived from the address while output enable is low,
 the inverse of the last byte otherwise. Shares the sequencer clock.
*/
`timescale 1ns/100ps
module sram_model
(
   input  wire logic        clock,
   input  wire logic [18:0] sramAddrLines,
   input  wire logic        sramOutputEnable_n,
   output wire logic [7:0]  sramDataIn
);
   logic [7:0] lastByte_r = 8'h00;
   wire  [7:0] byteNow    = sramAddrLines[7:0] ^ 8'h80;
   always @(posedge clock)
   begin
      if (!sramOutputEnable_n)
         lastByte_r <= byteNow;
   end
   assign sramDataIn = sramOutputEnable_n ? ~lastByte_r : byteNow;
endmodule // sram_model

// ### tb.sv
/*
 Testbench for the colour frame sequencer: APB tasks and frame pass checks.
 Assumes a 200 MHz clock and a shortened strobe delay.
*/
`timescale 1ns/100ps
module tb;
   localparam int DLY = 40;
   logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, oeN, r, g, b, pHi, pLo;
   logic [18:0] addr;
   logic [7:0]  din, idx;
   integer      num_errors = 0, num_checks = 0, cyc = 0, d, k, f1, f2, nz;
   always #2.5 clock = ~clock;
   color_frame_sequencer #(.STROBE_DELAY(DLY), .FRAME_LINES(2)) uut (.clock(clock), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sramAddrLines(addr),
      .sramDataIn(din), .sramDataOut(), .sramDataOe(), .sramWriteEnable_n(),
      .sramOutputEnable_n(oeN), .palettePageHi(pHi), .palettePageLo(pLo),
      .paletteIndexLines(idx), .paletteDataOut(), .paletteDataOe(),
      .redLedStrobe(r), .greenLedStrobe(g), .blueLedStrobe(b));
   sram_model mem (.clock(clock), .sramAddrLines(addr), .sramOutputEnable_n(oeN),
      .sramDataIn(din));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         num_errors++;
         give_verdict;
      end
   end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
      @(posedge clock);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(0, a, 32'h0);
      chk(rd, exp);
   endtask
   task run_pass(input logic [2:0] led, input logic [1:0] page, input logic [18:0] start,
                 input logic full, input integer lo, input integer hi);
      integer n, gap;
      while (oeN !== 1'b0) @(negedge clock);
      chk({pHi, pLo}, page);
      chk(addr, start);
      if (!full)
         return;
      n = 1;
      gap = 0;
      do
      begin
         @(negedge clock);
         if (oeN === 1'b0 && {r, g, b} === 3'b000)
         begin
            n++;
            gap = 0;
         end
         else
            gap++;
      end
      while ({r, g, b} === 3'b000);
      chk({r, g, b}, led);
      chk(n, 640);
      chk(gap >= lo && gap <= hi, 1);
   endtask
   initial
   begin
      apb(1, 12'h000, 32'h0);
      rst_n <= 1;
      rchk(12'h000, 32'h3);
      rchk(12'h004, 32'h0);
      rchk(12'h008, 32'h80000);
      rchk(12'h010, 32'h0);
      apb(1, 12'h008, 32'h123);
      rchk(12'h008, 32'h80123);
      for (d = 0; d < 4; d++)
      begin
         apb(1, 12'h000, 32'h3);
         apb(1, 12'h004, d);
         apb(1, 12'h000, 32'h0);
         f1 = -1;
         f2 = -1;
         nz = -1;
         for (k = 0; k < 40; k++)
         begin
            @(negedge clock);
            if (oeN === 1'b0 && f1 >= 0 && f2 < 0)
               f2 = k;
            if (oeN === 1'b0 && f1 < 0)
               f1 = k;
            if (d == 0 && nz >= 0 && k == nz + 1)
               chk(idx, 8'h00);
            if (d == 0 && nz < 0 && f1 >= 0 && k > f1 && idx !== 8'h00)
               nz = k;
         end
         chk(f2 - f1, 1 + (8 >> d));
      end
      apb(1, 12'h000, 32'h3);
      apb(1, 12'h008, 32'h80100);
      apb(1, 12'h004, 32'h3);
      apb(1, 12'h000, 32'h0);
      run_pass(3'b111, 2'b11, 19'h00100, 1, 0, 4);
      apb(1, 12'h000, 32'h3);
      apb(1, 12'h004, 32'hB);
      apb(1, 12'h000, 32'h0);
      run_pass(3'b100, 2'b11, 19'h00100, 1, DLY, DLY + 8);
      run_pass(3'b010, 2'b11, 19'h00380, 0, 0, 0);
      apb(1, 12'h000, 32'h3);
      apb(1, 12'h004, 32'hF);
      rchk(12'h004, 32'hF);
      apb(1, 12'h000, 32'h0);
      run_pass(3'b001, 2'b00, 19'h00100, 1, DLY, DLY + 8);
      run_pass(3'b100, 2'b01, 19'h00100, 0, 0, 0);
      give_verdict;
   end
endmodule // tb
bind color_frame_sequencer frame_seq_assertions chk_i (.clock(clock), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sramWriteEnable_n(sramWriteEnable_n),
   .sramDataOe(sramDataOe), .sramOutputEnable_n(sramOutputEnable_n),
   .paletteDataOe(paletteDataOe), .redLedStrobe(redLedStrobe),
   .greenLedStrobe(greenLedStrobe), .blueLedStrobe(blueLedStrobe));
